// ---- hdl/pobc_pkg.sv ----
// Constants and state type for the port output, blink and configuration block.
// Assumes one 8-bit register access port fed by a serial bus engine elsewhere.
package pobc_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] POBC_ADR_INPUT = 8'h00;
  localparam logic [7:0] POBC_ADR_PHASE0 = 8'h01;
  localparam logic [7:0] POBC_ADR_DIR = 8'h03;
  localparam logic [7:0] POBC_ADR_PHASE1 = 8'h09;
  localparam logic [7:0] POBC_ADR_MASTER = 8'h0E;
  localparam logic [7:0] POBC_ADR_CFG = 8'h0F;
  localparam logic [7:0] POBC_ADR_INTEN_LO = 8'h10;
  localparam logic [7:0] POBC_ADR_INTEN_HI = 8'h13;

  // ----------------------------------------
  // Configuration bit positions
  // ----------------------------------------
  localparam int POBC_CFG_BLINK_EN = 0;
  localparam int POBC_CFG_FLIP = 1;
  localparam int POBC_CFG_GLOBAL = 2;
  localparam int POBC_CFG_IRQ_EN = 3;
  localparam int POBC_CFG_LVL_PH0 = 4;
  localparam int POBC_CFG_LVL_PH1 = 5;
  localparam int POBC_CFG_STORED = 6;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [5:0] POBC_RST_CFG = 6'h0C;
  localparam logic [7:0] POBC_RST_DIR = 8'hFF;
  localparam logic [7:0] POBC_RST_PHASE = 8'hFF;
  localparam logic [7:0] POBC_RST_MASTER = 8'h0F;
  localparam logic [31:0] POBC_RST_INTEN = 32'hFFFFFFFF;

  // Register file plus output flops, one packed word
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] ph0;
    logic [7:0] ph1;
    logic [7:0] master;
    logic [31:0] inten;
    logic [5:0] cfg;
    logic [7:0] rdata;
    logic [7:0] port_oe;
    logic ninth_oe;
    logic [31:0] port_lvl;
    logic [3:0] ninth_lvl;
    logic init_done;
  } pobc_state_t;

endpackage

// ---- hdl/pobc_detect_if.sv ----
// Carrier between the control logic and the input change detector.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface pobc_detect_if;
  logic snap_req;
  logic [7:0] port_in;
  logic [7:0] watch;
  logic change;

  modport ctrl (output snap_req, output port_in, output watch, input change);
  modport det (input snap_req, input port_in, input watch, output change);
endinterface

// ---- hdl/pobc_change_det.sv ----
// Input snapshot and change comparator.
// Assumes port inputs are synchronous to ref_clk.
`timescale 1ns/10ps
module pobc_change_det (
  input wire logic ref_clk,
  input wire logic nrst,
  pobc_detect_if.det dif
);

  typedef struct packed {
    logic [7:0] snap;
    logic change;
  } pobc_det_t;

  pobc_det_t st_ff;
  pobc_det_t nxt_st;

  // ----------------------------------------
  // Snapshot and compare
  // ----------------------------------------
  // A fresh snapshot compares equal, so the flag drops on the same edge
  always_comb begin
    nxt_st = st_ff;
    if (dif.snap_req) begin
      nxt_st.snap = dif.port_in; // see RL14
    end
    // Only input ports are watched; change clears once inputs return, see RL15
    nxt_st.change = |((nxt_st.snap ^ dif.port_in) & dif.watch); // see RL14
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dif.change = st_ff.change;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_SNAP_CLEARS: assert property (@(posedge ref_clk) disable iff (!nrst) // see RL15
    dif.snap_req |=> !dif.change)
    else $error("change flag survived a snapshot");

endmodule

// ---- hdl/pobc_top.sv ----
// Configuration, direction and phase output control of an 8-port I/O expander.
// Assumes a serial bus engine presents byte accesses on reg_* for one cycle each.
`timescale 1ns/10ps

// What this block does
// RL1 - Blink off: output ports follow phase-0 register only.
// RL2 - Blink on: flip bit picks phase-0 (0) or phase-1 (1) register.
// RL3 - Selected phase bit 1 releases the open-drain port, 0 pulls it low.
// RL4 - Phase registers drive only output ports; input ports never driven.
// RL5 - Direction register at 0x03, bit n port n, 1 input, readable.
// RL6 - Global off: per-port intensity from 0x10-0x13, ninth from 0x0E upper nibble.
// RL7 - Global on: 0x0E low nibble is every output's intensity.
// RL8 - Interrupt enable makes ninth pin the active-low change interrupt.
// RL9 - Interrupt disabled: ninth pin is open-drain output from D5, D4.
// RL10 - Blink off: ninth pin low on D4=0, released on D4=1; D5 ignored.
// RL11 - Blink on: ninth pin follows D4 in phase 0, D5 in phase 1.
// RL12 - Config read bit 7 shows detected change; interrupt low then; bit 6 zero.
// RL13 - No change: status 0 and interrupt pin released.
// RL14 - Input register read or config write resnapshots inputs; differences flag change.
// RL15 - Change clears when inputs return or input register is read.
// RL16 - Reset: interrupt output, blink off, global on, all ports inputs.
// RL17 - Writes to config bits 7 and 6 are ignored.
module pobc_top import pobc_pkg::*; #(
  parameter int NPORT = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] port_in,
  output logic [7:0] port_out,
  output logic [7:0] port_oe,
  output logic [31:0] port_intensity,
  output logic ninth_dual_purpose_pin_out,
  output logic ninth_dual_purpose_pin_oe,
  output logic [3:0] ninth_intensity
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // The register map packs one port per data bit
  if (NPORT != 8) begin : g_bad_nport
    $error("pobc_top serves exactly eight ports");
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Open-drain pull request: a 0 level on a driven pin pulls low
  function automatic logic od_pull(input logic level, input logic is_out);
    od_pull = is_out & ~level;
  endfunction

  // Phase source: phase 1 only while blinking with flip set
  function automatic logic use_ph1(input logic [5:0] cfg);
    use_ph1 = cfg[POBC_CFG_BLINK_EN] & cfg[POBC_CFG_FLIP];
  endfunction

  // Per-port intensity bytes sit in one aligned block of four offsets
  function automatic logic is_inten(input logic [7:0] addr);
    is_inten = (addr >= POBC_ADR_INTEN_LO) && (addr <= POBC_ADR_INTEN_HI);
  endfunction

  pobc_state_t st_ff;
  pobc_state_t nxt_st;
  pobc_detect_if dif ();

  logic wr_cfg;
  logic rd_input;
  logic [7:0] sel_phase;
  logic ninth_lvl;

  // ----------------------------------------
  // Change detector
  // ----------------------------------------
  assign wr_cfg = reg_wr && (reg_addr == POBC_ADR_CFG);
  assign rd_input = reg_rd && (reg_addr == POBC_ADR_INPUT);
  // Turning an output into an input can raise a false change when its pin
  // differs from the snapshot; software re-reads the input register to clear it
  // The first cycle after reset release takes the power-up snapshot
  assign dif.snap_req = rd_input | wr_cfg | ~st_ff.init_done; // see RL14
  assign dif.port_in = port_in;
  assign dif.watch = st_ff.dir;

  pobc_change_det u_det (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .dif(dif)
  );

  // ----------------------------------------
  // Register writes, reads and output drive
  // ----------------------------------------
  // Outputs are built from next register values so they change on the same edge as the written register
  always_comb begin
    nxt_st = st_ff;
    sel_phase = '0;
    ninth_lvl = 1'b0;
    nxt_st.init_done = 1'b1;
    if (reg_wr) begin
      case (reg_addr)
        POBC_ADR_PHASE0: begin
          nxt_st.ph0 = reg_wdata;
        end
        POBC_ADR_PHASE1: begin
          nxt_st.ph1 = reg_wdata;
        end
        POBC_ADR_DIR: begin
          nxt_st.dir = reg_wdata; // see RL5
        end
        POBC_ADR_MASTER: begin
          nxt_st.master = reg_wdata;
        end
        POBC_ADR_CFG: begin
          nxt_st.cfg = reg_wdata[POBC_CFG_STORED-1:0]; // see RL17
        end
        default: begin
          // Input register and unmapped offsets ignore writes
          if (is_inten(reg_addr)) begin
            nxt_st.inten[8*reg_addr[1:0] +: 8] = reg_wdata; // see RL6
          end
        end
      endcase
    end

    // Read data held until the next read
    if (reg_rd) begin
      case (reg_addr)
        POBC_ADR_INPUT: nxt_st.rdata = port_in;
        POBC_ADR_PHASE0: nxt_st.rdata = st_ff.ph0;
        POBC_ADR_PHASE1: nxt_st.rdata = st_ff.ph1;
        POBC_ADR_DIR: nxt_st.rdata = st_ff.dir; // see RL5
        POBC_ADR_MASTER: nxt_st.rdata = st_ff.master;
        POBC_ADR_CFG: nxt_st.rdata = {dif.change, 1'b0, st_ff.cfg}; // see RL12, see RL13
        default: begin
          // Unmapped offsets read as zero
          if (is_inten(reg_addr)) begin
            nxt_st.rdata = st_ff.inten[8*reg_addr[1:0] +: 8];
          end else begin
            nxt_st.rdata = 8'h00;
          end
        end
      endcase
    end

    // Port drive from the selected phase register
    sel_phase = use_ph1(nxt_st.cfg) ? nxt_st.ph1 : nxt_st.ph0; // see RL1, see RL2
    for (int i = 0; i < NPORT; i++) begin
      nxt_st.port_oe[i] = od_pull(sel_phase[i], ~nxt_st.dir[i]); // see RL3, see RL4
      nxt_st.port_lvl[4*i +: 4] = nxt_st.cfg[POBC_CFG_GLOBAL] ? nxt_st.master[3:0] // see RL7
                                  : nxt_st.inten[4*i +: 4]; // see RL6
    end

    // Ninth pin: interrupt or general output
    if (use_ph1(nxt_st.cfg)) begin
      ninth_lvl = nxt_st.cfg[POBC_CFG_LVL_PH1]; // see RL11
    end else begin
      ninth_lvl = nxt_st.cfg[POBC_CFG_LVL_PH0]; // see RL10, see RL11
    end
    if (nxt_st.cfg[POBC_CFG_IRQ_EN]) begin
      nxt_st.ninth_oe = dif.change; // see RL8, see RL13
    end else begin
      nxt_st.ninth_oe = od_pull(ninth_lvl, 1'b1); // see RL9
    end
    nxt_st.ninth_lvl = nxt_st.cfg[POBC_CFG_GLOBAL] ? nxt_st.master[3:0] // see RL7
                       : nxt_st.master[7:4]; // see RL6
  end

  // Power-up values: all inputs, interrupt output, blink off, global on
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.dir <= POBC_RST_DIR; // see RL16
      st_ff.ph0 <= POBC_RST_PHASE;
      st_ff.ph1 <= POBC_RST_PHASE;
      st_ff.master <= POBC_RST_MASTER;
      st_ff.inten <= POBC_RST_INTEN;
      st_ff.cfg <= POBC_RST_CFG; // see RL16
      // Intensity flops start consistent with global mode, so no stale zero leaks out
      st_ff.port_lvl <= {NPORT{POBC_RST_MASTER[3:0]}};
      st_ff.ninth_lvl <= POBC_RST_MASTER[3:0];
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Output ports
  // ----------------------------------------
  // Pins only ever pull low, so the driven level is tied to a constant zero
  assign reg_rdata = st_ff.rdata;
  assign port_out = st_ff.port_lvl[31:24] & 8'h00;
  assign port_oe = st_ff.port_oe;
  assign port_intensity = st_ff.port_lvl;
  assign ninth_dual_purpose_pin_out = st_ff.ninth_lvl[0] & 1'b0;
  assign ninth_dual_purpose_pin_oe = st_ff.ninth_oe;
  assign ninth_intensity = st_ff.ninth_lvl;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_cfg_write;
    reg_wr && reg_addr == POBC_ADR_CFG;
  endsequence

  sequence s_quiet;
    !reg_wr && !reg_rd;
  endsequence

  sequence s_input_read;
    reg_rd && reg_addr == POBC_ADR_INPUT;
  endsequence

  AST_BLINK_OFF_PH0: assert property ( // see RL1
    !st_ff.cfg[POBC_CFG_BLINK_EN] |-> port_oe == (~st_ff.dir & ~st_ff.ph0))
    else $error("blink off but ports not from phase 0");

  AST_FLIP_PH1: assert property ( // see RL2
    st_ff.cfg[POBC_CFG_BLINK_EN] && st_ff.cfg[POBC_CFG_FLIP] |-> port_oe == (~st_ff.dir & ~st_ff.ph1))
    else $error("flip set but ports not from phase 1");

  AST_INPUTS_UNDRIVEN: assert property ( // see RL4
    (port_oe & st_ff.dir) == 8'h00)
    else $error("an input port is driven");

  AST_DIR_WRITE_READ: assert property ( // see RL5
    reg_wr && reg_addr == POBC_ADR_DIR ##1 s_quiet ##1 reg_rd && reg_addr == POBC_ADR_DIR
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("direction read-back differs from write");

  AST_GLOBAL_LEVEL: assert property ( // see RL7
    st_ff.cfg[POBC_CFG_GLOBAL] |-> port_intensity[3:0] == st_ff.master[3:0]
    && ninth_intensity == st_ff.master[3:0])
    else $error("global intensity not applied");

  AST_IRQ_PIN: assert property ( // see RL8
    s_quiet ##1 st_ff.cfg[POBC_CFG_IRQ_EN] |-> ninth_dual_purpose_pin_oe == $past(dif.change))
    else $error("interrupt pin does not follow change flag");

  AST_GPO_NO_BLINK: assert property ( // see RL10
    !st_ff.cfg[POBC_CFG_IRQ_EN] && !st_ff.cfg[POBC_CFG_BLINK_EN]
    |-> ninth_dual_purpose_pin_oe == !st_ff.cfg[POBC_CFG_LVL_PH0])
    else $error("ninth output ignores phase-0 level bit");

  AST_GPO_PHASE1: assert property ( // see RL11
    !st_ff.cfg[POBC_CFG_IRQ_EN] && st_ff.cfg[POBC_CFG_BLINK_EN] && st_ff.cfg[POBC_CFG_FLIP]
    |-> ninth_dual_purpose_pin_oe == !st_ff.cfg[POBC_CFG_LVL_PH1])
    else $error("ninth output ignores phase-1 level bit");

  AST_STATUS_READ: assert property ( // see RL12
    reg_rd && reg_addr == POBC_ADR_CFG |=> reg_rdata[7] == $past(dif.change) && !reg_rdata[6])
    else $error("status read-back wrong");

  AST_CFG_WRITE: assert property ( // see RL17
    s_cfg_write |=> st_ff.cfg == $past(reg_wdata[POBC_CFG_STORED-1:0]))
    else $error("configuration write not stored");

  // Back-to-back writes are legal, so holding is judged cycle by cycle
  AST_CFG_HOLD: assert property ( // see RL17
    !(reg_wr && reg_addr == POBC_ADR_CFG) |=> $stable(st_ff.cfg))
    else $error("configuration changed without a write");

  AST_CFG_RESNAP: assert property ( // see RL14
    s_cfg_write |=> !dif.change)
    else $error("configuration write did not resnapshot");

  AST_INPUT_RESNAP: assert property ( // see RL15
    s_input_read |=> !dif.change)
    else $error("input register read did not clear change");

  AST_FLIP_PH0: assert property ( // see RL2
    st_ff.cfg[POBC_CFG_BLINK_EN] && !st_ff.cfg[POBC_CFG_FLIP] |-> port_oe == (~st_ff.dir & ~st_ff.ph0))
    else $error("flip clear but ports not from phase 0");

  AST_RELEASED_HIGH: assert property ( // see RL3
    (port_oe & (use_ph1(st_ff.cfg) ? st_ff.ph1 : st_ff.ph0)) == 8'h00)
    else $error("a port with level bit one is pulled low");

  AST_GLOBAL_OFF_LEVEL: assert property ( // see RL6
    !st_ff.cfg[POBC_CFG_GLOBAL] |-> port_intensity == st_ff.inten
    && ninth_intensity == st_ff.master[7:4])
    else $error("per-port intensity not applied");

  AST_GPO_PHASE0: assert property ( // see RL11
    !st_ff.cfg[POBC_CFG_IRQ_EN] && st_ff.cfg[POBC_CFG_BLINK_EN] && !st_ff.cfg[POBC_CFG_FLIP]
    |-> ninth_dual_purpose_pin_oe == !st_ff.cfg[POBC_CFG_LVL_PH0])
    else $error("ninth output ignores phase-0 level bit while blinking");

  AST_STATUS_CLEAR: assert property ( // see RL13
    reg_rd && reg_addr == POBC_ADR_CFG && !dif.change |=> !reg_rdata[7])
    else $error("status set with no change");

  AST_IRQ_RELEASED: assert property ( // see RL13
    st_ff.cfg[POBC_CFG_IRQ_EN] && !dif.change |=> !st_ff.cfg[POBC_CFG_IRQ_EN] || !ninth_dual_purpose_pin_oe)
    else $error("interrupt pin pulled with no change");

  // Only the first cycle after release has init_done low
  AST_RESET_STATE: assert property ( // see RL16
    !st_ff.init_done |-> st_ff.dir == POBC_RST_DIR && st_ff.cfg == POBC_RST_CFG
    && ninth_intensity == POBC_RST_MASTER[3:0])
    else $error("power-up register state wrong");

endmodule

// ---- verification/pobc_host_model.sv ----
// Register-bus host model: one-byte writes and reads on the reg_* strobes.
// Assumes callers enter each task just after a rising edge of ref_clk.
`timescale 1ns/10ps
module pobc_host_model (
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // ----------------------------------------
  // Idle bus
  // ----------------------------------------
  // Strobes low from time zero; address and data are not trusted while idle
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // One-cycle write pulse, then one quiet edge so a following strobe never rises in the same step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1 reg_wr = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  // Read data is taken one full cycle after the strobe edge, when it has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1 reg_rd = 1'b0;
    @(posedge ref_clk);
    #1 q = reg_rdata;
  endtask
endmodule

// ---- verification/port_output_blink_config_tb_top.sv ----
// Self-checking bench for the configuration and port output block.
// Assumes pulled-up open-drain pins; ext holds the external drive of each pin.
`timescale 1ns/10ps
module port_output_blink_config_tb_top import pobc_pkg::*;;
  logic ref_clk, nrst, reg_wr, reg_rd, n9_out, n9_oe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ext, port_in, port_out, port_oe, q, d, p0, p1, m, c;
  logic [31:0] port_intensity, iv;
  logic [3:0] n9_int;
  int num_errors = 0;
  int checked = 0;
  integer seed = 32'h96b783ee;

  // ----------------------------------------
  // Clock, pins and instances
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // A pulled-low pin reads low whatever the outside drives
  assign port_in = ext & ~port_oe;

  pobc_host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  pobc_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_in(port_in), .port_out(port_out),
    .port_oe(port_oe), .port_intensity(port_intensity), .ninth_dual_purpose_pin_out(n9_out),
    .ninth_dual_purpose_pin_oe(n9_oe), .ninth_intensity(n9_int));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Pull-down enables {ninth, ports}; chg is the live change flag
  function automatic logic [8:0] exp_oe(input logic [7:0] dr, input logic [7:0] a0, input logic [7:0] a1,
    input logic [7:0] cf, input logic chg);
    logic sw;
    sw = cf[0] & cf[1];
    exp_oe = {cf[3] ? chg : ~(sw ? cf[5] : cf[4]), ~(sw ? a1 : a0) & ~dr};
  endfunction

  // Nibble mask of output ports; input ports' intensity is left unjudged
  function automatic logic [31:0] omask(input logic [7:0] dr);
    for (int i = 0; i < 8; i++) begin
      omask[4*i+:4] = {4{~dr[i]}};
    end
  endfunction

  task automatic settle();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // Whole run needs under 2000 cycles; 10000 leaves a wide margin
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    ext = 8'hFF;
    repeat (20) @(posedge ref_clk);
    #1 nrst = 1'b1;
    @(posedge ref_clk);
    #1;
    // Power-up state
    host_u.rd(POBC_ADR_DIR, q);
    chk(q, 8'hFF);
    host_u.rd(POBC_ADR_CFG, q);
    chk(q, 8'h0C);
    chk({n9_oe, port_oe}, 9'h000);
    // Status and reserved bits cannot be written
    host_u.wr(POBC_ADR_CFG, 8'hC8);
    host_u.rd(POBC_ADR_CFG, q);
    chk(q, 8'h08);
    // Change sets the flag, returning clears it
    ext = 8'hFE;
    settle();
    chk(n9_oe, 1'b1);
    host_u.rd(POBC_ADR_CFG, q);
    chk(q, 8'h88);
    ext = 8'hFF;
    settle();
    chk(n9_oe, 1'b0);
    // Reading the input register takes a fresh snapshot
    ext = 8'hFE;
    settle();
    host_u.rd(POBC_ADR_INPUT, q);
    chk(q, 8'hFE);
    settle();
    chk(n9_oe, 1'b0);
    // Interrupt off: status still shows, pin follows the level bit
    host_u.wr(POBC_ADR_CFG, 8'h10);
    ext = 8'hFF;
    settle();
    chk(n9_oe, 1'b0);
    host_u.rd(POBC_ADR_CFG, q);
    chk(q, 8'h90);
    host_u.rd(8'h05, q);
    chk(q, 8'h00);
    // Random configurations; the first four sweep every blink code
    for (int i = 0; i < 24; i++) begin
      ext = 8'($random(seed));
      d = 8'($random(seed));
      p0 = 8'($random(seed));
      p1 = 8'($random(seed));
      m = 8'($random(seed));
      iv = $random(seed);
      c = 8'($random(seed));
      if (i < 4) begin
        c[1:0] = i[1:0];
      end
      // Configuration last, so its snapshot sees settled pins
      host_u.wr(POBC_ADR_DIR, d);
      host_u.wr(POBC_ADR_PHASE0, p0);
      host_u.wr(POBC_ADR_PHASE1, p1);
      host_u.wr(POBC_ADR_MASTER, m);
      for (int k = 0; k < 4; k++) begin
        host_u.wr(POBC_ADR_INTEN_LO + 8'(k), iv[8*k+:8]);
      end
      host_u.wr(POBC_ADR_CFG, c);
      settle();
      chk({n9_oe, port_oe}, exp_oe(d, p0, p1, c, 1'b0));
      chk({n9_out, port_out}, 9'h000);
      chk(port_intensity & omask(d), (c[2] ? {8{m[3:0]}} : iv) & omask(d));
      if (!c[2]) begin
        chk(n9_int, m[7:4]);
      end else begin
        chk(n9_int, m[3:0]);
      end
      // Rewrite direction and read it straight back after one quiet edge
      host_u.wr(POBC_ADR_DIR, d);
      host_u.rd(POBC_ADR_DIR, q);
      chk(q, d);
      host_u.rd(POBC_ADR_CFG, q);
      chk(q, {2'b00, c[5:0]});
    end
    give_verdict();
  end
endmodule
